// ==== core/mode_map_pkg.sv ====
// constants for the mode and memory map control block
package mode_map_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses within the control block)
	// ------------------------------------------------------------
	localparam logic [15:0] port_a_data_off        = 16'h1000;
	localparam logic [15:0] reserved_one_off       = 16'h1001;
	localparam logic [15:0] parallel_io_control_off = 16'h1002;
	localparam logic [15:0] port_c_data_off        = 16'h1003;
	localparam logic [15:0] port_b_output_off      = 16'h1004;
	localparam logic [15:0] port_c_latched_alt_off = 16'h1005;
	localparam logic [15:0] reserved_two_off       = 16'h1006;
	localparam logic [15:0] mode_ctrl_off          = 16'h103C;
	localparam logic [15:0] relocation_off         = 16'h103D;
	localparam logic [15:0] factory_test_off       = 16'h103E;
	localparam logic [15:0] timer_mask_two_off     = 16'h1024;
	localparam logic [15:0] option_off             = 16'h1039;
	// ------------------------------------------------------------
	// map layout
	// ------------------------------------------------------------
	localparam logic [15:0] vector_base_normal     = 16'hFFC0;
	localparam logic [15:0] vector_base_test       = 16'hBFC0;
	localparam logic [15:0] reg_block_size         = 16'h0040;
	localparam logic [15:0] ram_block_size         = 16'h0100;
	localparam logic [7:0]  relocation_reset       = 8'h01;
	localparam logic [7:0]  reg_reset              = 8'h00;
	// protected registers may be written within this many nanoseconds after reset
	localparam int          protect_window_ns      = 320;
	localparam int          clk_period_ns          = 5;
	localparam int          protect_window_cycles  = protect_window_ns / clk_period_ns;
	localparam logic [7:0]  protect_window_count   = 8'(protect_window_cycles);
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int special_mode_bit_pos = 1;
	localparam int mode_select_bit_pos  = 0;
	// ------------------------------------------------------------
	// operating modes, one-hot
	// ------------------------------------------------------------
	typedef enum logic [3:0]
	{
		mode_single_chip = 4'h1,
		mode_expanded    = 4'h2,
		mode_bootstrap   = 4'h4,
		mode_test        = 4'h8
	} op_mode_t;
endpackage : mode_map_pkg

// ==== core/map_decode.sv ====
// address decoder for relocatable ram and control register block
`timescale 1ns/1ps
module map_decode
	import mode_map_pkg::*;
(
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  relocation_i,
	output logic             reg_hit_o,
	output logic [5:0]       reg_index_o,
	output logic             ram_hit_o
);
	logic [15:0] reg_base;
	logic [15:0] ram_base;
	// upper nibble places the ram, lower nibble the register block
	assign reg_base    = {relocation_i[3:0], 12'h000};
	assign ram_base    = {relocation_i[7:4], 12'h000};
	assign reg_hit_o   = (addr_i - reg_base) < reg_block_size;
	assign reg_index_o = 6'(addr_i - reg_base);
	assign ram_hit_o   = !reg_hit_o && ((addr_i - ram_base) < ram_block_size);
endmodule : map_decode

// ==== core/mode_map_ctrl.sv ====
// operating mode, memory map and parallel port register control
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module mode_map_ctrl
	import mode_map_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [1:0]  mode_pins_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [7:0]       rdata_o,
	input  wire logic [7:0]  port_a_pins_i,
	input  wire logic [7:0]  port_c_pins_i,
	input  wire logic [15:0] cpu_addr_i,
	input  wire logic        cpu_rw_i,
	input  wire logic [7:0]  cpu_wdata_i,
	output logic [7:0]       port_b_o,
	output logic [7:0]       port_c_o,
	output logic             port_c_oe_n_o,
	output logic             address_strobe_o,
	output logic             rw_o,
	output logic [15:0]      vector_base_o,
	output logic [3:0]       op_mode_o,
	output logic [7:0]       factory_test_o,
	output logic [7:0]       parallel_io_control_o,
	output logic [7:0]       relocation_o
);
	import mode_map_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0]  mode_s1_reg, mode_s2_reg;
	logic [7:0]  pa_s1_reg, pa_s2_reg, pc_s1_reg, pc_s2_reg;
	always_ff @(posedge clk_i)
	begin
		mode_s1_reg <= mode_pins_i;
		mode_s2_reg <= mode_s1_reg;
		pa_s1_reg   <= port_a_pins_i;
		pa_s2_reg   <= pa_s1_reg;
		pc_s1_reg   <= port_c_pins_i;
		pc_s2_reg   <= pc_s1_reg;
	end

	// ------------------------------------------------------------
	// mode state
	// ------------------------------------------------------------
	op_mode_t    mode_reg, mode_next;
	logic        strap_done_reg, strap_done_next;
	logic [7:0]  window_reg, window_next;
	logic [7:0]  port_a_reg, port_a_next, parallel_io_control_reg, parallel_io_control_next;
	logic [7:0]  port_b_reg, port_b_next, port_c_reg, port_c_next;
	logic [7:0]  latch_c_reg, latch_c_next, reloc_reg, reloc_next;
	logic [7:0]  test_reg, test_next, timer_mask_two_reg, timer_mask_two_next, option_reg, option_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic [15:0] vec_reg, vec_next;
	logic [7:0]  pb_reg, pb_next, pc_reg, pc_next;
	logic        oe_n_reg, oe_n_next, as_reg, as_next, rw_reg, rw_next;
	logic        reg_hit, ram_hit;
	logic [5:0]  reg_index;
	logic        is_test, is_expanded_bus, protect_open, wr_reg_hit;
	// decoded write hits as plain nets, so the checks sample them at the edge
	logic        wr_test_hit, wr_mode_hit, wr_reloc_hit, wr_parallel_io_control_hit;

	map_decode u_decode
	(
		.addr_i       (addr_i),
		.relocation_i (reloc_reg),
		.reg_hit_o    (reg_hit),
		.reg_index_o  (reg_index),
		.ram_hit_o    (ram_hit)
	);

	function automatic op_mode_t decode_mode(input logic [1:0] bits);
		unique case (bits)
			2'b00:   decode_mode = mode_bootstrap;
			2'b01:   decode_mode = mode_test;
			2'b10:   decode_mode = mode_single_chip;
			default: decode_mode = mode_expanded;
		endcase
	endfunction : decode_mode

	function automatic logic hit(input logic [15:0] off);
		hit = reg_hit && (reg_index == 6'(off - port_a_data_off));
	endfunction : hit

	assign is_test         = (mode_reg == mode_test);
	assign is_expanded_bus = (mode_reg == mode_expanded) || is_test;
	assign protect_open    = is_test || (window_reg != 8'h00);
	assign wr_reg_hit      = wr_i && reg_hit;
	assign wr_test_hit     = wr_reg_hit && hit(factory_test_off);
	assign wr_mode_hit     = wr_reg_hit && hit(mode_ctrl_off);
	assign wr_reloc_hit    = wr_reg_hit && hit(relocation_off);
	assign wr_parallel_io_control_hit     = wr_reg_hit && hit(parallel_io_control_off);

	always_comb
	begin
		mode_next       = mode_reg;
		strap_done_next = 1'b1;
		window_next     = (window_reg != 8'h00) ? window_reg - 8'h01 : 8'h00;
		port_a_next     = port_a_reg;
		parallel_io_control_next       = parallel_io_control_reg;
		port_b_next     = port_b_reg;
		port_c_next     = port_c_reg;
		latch_c_next    = latch_c_reg;
		reloc_next      = reloc_reg;
		test_next       = test_reg;
		timer_mask_two_next      = timer_mask_two_reg;
		option_next     = option_reg;
		rdata_next      = 8'h00;
		if (!strap_done_reg)
			mode_next = decode_mode(mode_s2_reg);
		if (wr_reg_hit)
		begin
			if (hit(port_a_data_off))
				port_a_next = wdata_i;
			if (hit(parallel_io_control_off))
				parallel_io_control_next = {parallel_io_control_reg[7], wdata_i[6:0]};
			if (hit(port_c_data_off))
				port_c_next = wdata_i;
			if (hit(port_b_output_off))
				port_b_next = wdata_i;
			if (hit(relocation_off) && protect_open)
				reloc_next = wdata_i;
			if (hit(timer_mask_two_off) && protect_open)
				timer_mask_two_next = wdata_i;
			if (hit(option_off) && protect_open)
				option_next = wdata_i;
			if (hit(factory_test_off) && is_test)
				test_next = wdata_i;
			if (hit(mode_ctrl_off) && (mode_reg == mode_test || mode_reg == mode_bootstrap))
			begin
				// special modes may drop to a normal mode, never climb back
				if (!wdata_i[special_mode_bit_pos])
				begin
					mode_next = wdata_i[mode_select_bit_pos] ? mode_expanded : mode_single_chip;
					test_next = 8'h00;
				end
			end
		end
		if (!is_test)
			test_next = 8'h00;
		latch_c_next = port_c_reg == 8'h00 ? latch_c_reg : pc_s2_reg;
		if (rd_i && reg_hit)
		begin
			unique case (1'b1)
				hit(port_a_data_off):         rdata_next = pa_s2_reg;
				hit(parallel_io_control_off): rdata_next = parallel_io_control_reg;
				hit(port_c_data_off):         rdata_next = pc_s2_reg;
				hit(port_b_output_off):       rdata_next = port_b_reg;
				hit(port_c_latched_alt_off):  rdata_next = latch_c_reg;
				hit(relocation_off):          rdata_next = reloc_reg;
				hit(timer_mask_two_off):      rdata_next = timer_mask_two_reg;
				hit(option_off):              rdata_next = option_reg;
				hit(factory_test_off):        rdata_next = is_test ? test_reg : 8'h00;
				hit(mode_ctrl_off):           rdata_next = {4'h0, mode_reg};
				default:                      rdata_next = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// external bus and vector selection
	// ------------------------------------------------------------
	always_comb
	begin
		vec_next  = is_test ? vector_base_test : vector_base_normal;
		pb_next   = port_b_reg;
		pc_next   = port_c_reg;
		oe_n_next = 1'b0;
		as_next   = 1'b0;
		rw_next   = 1'b1;
		if (is_expanded_bus)
		begin
			pb_next   = cpu_addr_i[15:8];
			pc_next   = cpu_rw_i ? cpu_addr_i[7:0] : cpu_wdata_i;
			oe_n_next = 1'b0;
			as_next   = 1'b1;
			rw_next   = cpu_rw_i;
		end
		else
		begin
			// no address leaves the chip in single-chip modes
			pb_next = port_b_reg;
			pc_next = port_c_reg;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			mode_reg       <= mode_single_chip;
			strap_done_reg <= 1'b0;
			window_reg     <= protect_window_count;
			port_a_reg     <= reg_reset;
			parallel_io_control_reg       <= reg_reset;
			port_b_reg     <= reg_reset;
			port_c_reg     <= reg_reset;
			latch_c_reg    <= reg_reset;
			reloc_reg      <= relocation_reset;
			test_reg       <= reg_reset;
			timer_mask_two_reg      <= reg_reset;
			option_reg     <= reg_reset;
			rdata_reg      <= reg_reset;
			vec_reg        <= vector_base_normal;
			pb_reg         <= reg_reset;
			pc_reg         <= reg_reset;
			oe_n_reg       <= 1'b1;
			as_reg         <= 1'b0;
			rw_reg         <= 1'b1;
		end
		else
		begin
			mode_reg       <= mode_next;
			strap_done_reg <= strap_done_next;
			window_reg     <= window_next;
			port_a_reg     <= port_a_next;
			parallel_io_control_reg       <= parallel_io_control_next;
			port_b_reg     <= port_b_next;
			port_c_reg     <= port_c_next;
			latch_c_reg    <= latch_c_next;
			reloc_reg      <= reloc_next;
			test_reg       <= test_next;
			timer_mask_two_reg      <= timer_mask_two_next;
			option_reg     <= option_next;
			rdata_reg      <= rdata_next;
			vec_reg        <= vec_next;
			pb_reg         <= pb_next;
			pc_reg         <= pc_next;
			oe_n_reg       <= oe_n_next;
			as_reg         <= as_next;
			rw_reg         <= rw_next;
		end
	end

	assign rdata_o               = rdata_reg;
	assign port_b_o              = pb_reg;
	assign port_c_o              = pc_reg;
	assign port_c_oe_n_o         = oe_n_reg;
	assign address_strobe_o      = as_reg;
	assign rw_o                  = rw_reg;
	assign vector_base_o         = vec_reg;
	assign op_mode_o             = mode_reg;
	assign factory_test_o        = test_reg;
	assign parallel_io_control_o = parallel_io_control_reg;
	assign relocation_o          = reloc_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence leave_test_s;
		is_test && wr_mode_hit && !wdata_i[special_mode_bit_pos];
	endsequence

	vector_select_a: assert property (@(posedge clk_i) disable iff (srst_i)
		is_test |=> vector_base_o == vector_base_test)
		else $error("test vector base wrong");
	test_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!is_test |=> factory_test_o == 8'h00)
		else $error("factory test active outside test mode");
	mode_exit_a: assert property (@(posedge clk_i) disable iff (srst_i)
		leave_test_s |=> !is_test ##1 vector_base_o == vector_base_normal)
		else $error("test mode exit failed");
	test_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
		is_test && wr_test_hit |=> factory_test_o == $past(wdata_i))
		else $error("factory test write lost");
	protect_lock_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!protect_open && wr_reloc_hit |=> $stable(relocation_o))
		else $error("protected write accepted late");
	single_pins_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!is_expanded_bus && $past(!is_expanded_bus) |-> !address_strobe_o && port_b_o == $past(port_b_reg))
		else $error("address on pins in single chip");
	bus_strobe_a: assert property (@(posedge clk_i) disable iff (srst_i)
		is_expanded_bus |=> address_strobe_o && rw_o == $past(cpu_rw_i))
		else $error("bus strobe missing");
	high_addr_a: assert property (@(posedge clk_i) disable iff (srst_i)
		is_expanded_bus |=> port_b_o == $past(cpu_addr_i[15:8]))
		else $error("high address not on port b");
	parallel_io_control_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
		wr_parallel_io_control_hit |=> parallel_io_control_o[6:0] == $past(wdata_i[6:0]))
		else $error("parallel io control write lost");
endmodule : mode_map_ctrl

// ==== bench/ext_bus_partner.sv ====
// behavioural port c pin model on the multiplexed expansion bus
`timescale 1ns/1ps
module ext_bus_partner
(
	input  wire logic       clk_i,
	input  wire logic [7:0] addr_data_i,
	input  wire logic       drive_n_i,
	output logic [7:0]      pins_o
);
	// ----------------------------------------------------------
	// port c lines as seen at the pins
	// ----------------------------------------------------------
	logic [7:0] churn_reg = 8'h00;
	always @(posedge clk_i)
		churn_reg <= churn_reg + 8'h35;
	// released lines change every cycle so stale data never looks valid
	assign pins_o = drive_n_i ? churn_reg : addr_data_i;
endmodule : ext_bus_partner

// ==== bench/mode_map_ctrl_tb_top.sv ====
// self-checking testbench for the mode and memory map control block
`timescale 1ns/1ps
module mode_map_ctrl_tb_top;
	import mode_map_pkg::*;
	// ----------------------------------------------------------
	// signals
	// ----------------------------------------------------------
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [1:0]  mode_pins_i = 2'h2;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [15:0] cpu_addr_i = 16'h0000;
	logic        cpu_rw_i = 1'b1;
	logic [7:0]  cpu_wdata_i = 8'h00;
	logic [7:0]  port_a_pins_i = 8'h3C;
	logic [7:0]  port_c_pins_i;
	logic [7:0]  rdata_o, port_b_o, port_c_o, factory_test_o, parallel_io_control_o, relocation_o;
	logic        port_c_oe_n_o, address_strobe_o, rw_o;
	logic [15:0] vector_base_o;
	logic [3:0]  op_mode_o;
	int          errors = 0;
	int          n_compared = 0;
	always #2.5 clk_i = ~clk_i;
	mode_map_ctrl i_dut (.clk_i(clk_i), .srst_i(srst_i), .mode_pins_i(mode_pins_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_a_pins_i(port_a_pins_i),
		.port_c_pins_i(port_c_pins_i), .cpu_addr_i(cpu_addr_i), .cpu_rw_i(cpu_rw_i),
		.cpu_wdata_i(cpu_wdata_i), .port_b_o(port_b_o), .port_c_o(port_c_o), .port_c_oe_n_o(port_c_oe_n_o),
		.address_strobe_o(address_strobe_o), .rw_o(rw_o), .vector_base_o(vector_base_o),
		.op_mode_o(op_mode_o), .factory_test_o(factory_test_o),
		.parallel_io_control_o(parallel_io_control_o), .relocation_o(relocation_o));
	ext_bus_partner i_partner (.clk_i(clk_i), .addr_data_i(port_c_o), .drive_n_i(port_c_oe_n_o),
		.pins_o(port_c_pins_i));
	// ----------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic final_report();
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	// straps settle before release; the first request waits past the capture edge
	task automatic do_reset(input logic [1:0] m);
		mode_pins_i <= m;
		srst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : do_reset
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : reg_wr
	task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : reg_rd
	task automatic bus_cycle(input logic [15:0] a, input logic rw, input logic [7:0] d);
		@(posedge clk_i);
		cpu_addr_i <= a;
		cpu_rw_i <= rw;
		cpu_wdata_i <= d;
		@(posedge clk_i);
		#1;
	endtask : bus_cycle
	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic single_chip_scenario();
		logic [7:0] d;
		do_reset(2'h2);
		check("op_mode", op_mode_o, mode_single_chip);
		check("vector", vector_base_o, 16'hFFC0);
		check("reloc", relocation_o, 8'h01);
		reg_wr(port_b_output_off, 8'hA5);
		bus_cycle(16'h8055, 1'b0, 8'h11);
		check("strobe", address_strobe_o, 1'b0);
		check("port_b", port_b_o, 8'hA5);
		reg_wr(parallel_io_control_off, 8'hFF);
		check("parallel_io_control", parallel_io_control_o, 8'h7F);
		reg_rd(parallel_io_control_off, d);
		check("parallel_io_control_rd", d, 8'h7F);
		reg_wr(port_c_data_off, 8'h5C);
		// pins come back through the output flop and two sync stages
		repeat (3) @(posedge clk_i);
		reg_rd(port_c_data_off, d);
		check("port_c_rd", d, 8'h5C);
		reg_rd(port_c_latched_alt_off, d);
		check("port_c_latched", d, 8'h5C);
		reg_rd(port_a_data_off, d);
		check("port_a_rd", d, 8'h3C);
		reg_rd(reserved_one_off, d);
		check("reserved", d, 8'h00);
		reg_wr(factory_test_off, 8'h5A);
		check("test_reg", factory_test_o, 8'h00);
		// the timed window has run out by now
		repeat (protect_window_cycles + 4) @(posedge clk_i);
		reg_wr(relocation_off, 8'h02);
		check("reloc_late", relocation_o, 8'h01);
	endtask : single_chip_scenario
	task automatic test_mode_scenario();
		logic [7:0] d;
		do_reset(2'h1);
		check("op_mode", op_mode_o, mode_test);
		check("vector", vector_base_o, 16'hBFC0);
		reg_wr(factory_test_off, 8'h5A);
		check("test_reg", factory_test_o, 8'h5A);
		repeat (protect_window_cycles + 4) @(posedge clk_i);
		reg_wr(relocation_off, 8'h03);
		reg_wr(relocation_off + 16'h2000, 8'h02);
		check("reloc", relocation_o, 8'h02);
		reg_rd(port_a_data_off + 16'h1000, d);
		check("moved_rd", d, 8'h3C);
		reg_rd(port_a_data_off, d);
		check("old_rd", d, 8'h00);
		bus_cycle(16'h1234, 1'b0, 8'h77);
		check("bus_hi", port_b_o, 8'h12);
		check("bus_data", port_c_o, 8'h77);
		check("bus_oe_n", port_c_oe_n_o, 1'b0);
		check("bus_as", address_strobe_o, 1'b1);
		check("bus_rw", rw_o, 1'b0);
		reg_wr(mode_ctrl_off + 16'h1000, 8'h01);
		@(posedge clk_i);
		#1;
		check("exit_mode", op_mode_o, mode_expanded);
		check("exit_vec", vector_base_o, 16'hFFC0);
		check("exit_test", factory_test_o, 8'h00);
		reg_wr(relocation_off + 16'h1000, 8'h01);
		check("exit_reloc", relocation_o, 8'h02);
		reg_wr(factory_test_off + 16'h1000, 8'hA5);
		check("exit_tw", factory_test_o, 8'h00);
	endtask : test_mode_scenario
	task automatic expanded_and_boot_scenario();
		do_reset(2'h3);
		check("op_mode", op_mode_o, mode_expanded);
		bus_cycle(16'h8055, 1'b1, 8'h00);
		check("bus_hi", port_b_o, 8'h80);
		check("bus_lo", port_c_o, 8'h55);
		check("bus_rw", rw_o, 1'b1);
		bus_cycle(16'h1003, 1'b1, 8'h00);
		check("int_hi", port_b_o, 8'h10);
		check("int_as", address_strobe_o, 1'b1);
		do_reset(2'h0);
		check("op_mode_b", op_mode_o, mode_bootstrap);
		bus_cycle(16'hC0DE, 1'b1, 8'h00);
		check("boot_as", address_strobe_o, 1'b0);
	endtask : expanded_and_boot_scenario
	// ----------------------------------------------------------
	// run control
	// ----------------------------------------------------------
	initial
	begin
		single_chip_scenario();
		test_mode_scenario();
		expanded_and_boot_scenario();
		final_report();
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		errors++;
		final_report();
	end
endmodule : mode_map_ctrl_tb_top
